// ==== src/led_strap_map.vh ====
// constants for the speed/activity lamp and strap capture block
`ifndef LED_STRAP_MAP_VH
`define LED_STRAP_MAP_VH

// management register addresses for the captured strap and the indicator mode
`define CTRL0_ADDR        5'h00
`define AN_ADV_ADDR       5'h04
`define PHY_CTRL2_ADDR    5'h1F

// field positions
`define CTRL0_SPEED_BIT   13
`define LED_MODE_MSB      5
`define LED_MODE_LSB      4

// indicator modes
`define LED_MODE_SPEED    2'h0
`define LED_MODE_ACT      2'h1
`define LED_MODE_RSV2     2'h2
`define LED_MODE_RSV3     2'h3

// reset values: pull-up default is 100 Mbps, lamp off
`define STRAP_PIN_DEFAULT 1'h1
`define LAMP_OFF_LEVEL    1'h1
`define LAMP_ON_LEVEL     1'h0

// clock rate and lamp blink timing
`define CLK_KHZ           20000
`define BLINK_HALF_MS     25
`define BLINK_HALF_CYC    (`BLINK_HALF_MS * `CLK_KHZ)

// synchroniser depth, edges before the strap sample is settled
`define SYNC_STAGES       2
`define STRAP_SETTLE_CYC  2'h2

`endif

// ==== src/pin_sync.v ====
// two flip-flop synchroniser for pins from outside the clock domain
module pin_sync #(
  parameter WIDTH    = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  // clock and reset
  input  wire             clk,
  input  wire             arst_n,
  // asynchronous input and settled output
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_reg <= RESET_VAL;
      sync_out <= RESET_VAL;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // pin_sync

// ==== src/led_strap_mii_pin_control.v ====
// speed/activity lamp pin with speed strap capture and mii nibble qualification
`include "led_strap_map.vh"

module led_strap_mii_pin_control #(
  parameter BLINK_HALF_CYC = `BLINK_HALF_CYC
) (
  // clock and chip reset
  input  wire       clk,
  input  wire       arst_n,
  // speed/activity indicator pin, three-signal form
  input  wire       speed_activity_indicator_pin_in,
  output wire       speed_activity_indicator_pin_out,
  output wire       speed_activity_indicator_pin_oe,
  // lamp control from the core
  input  wire [1:0] led_mode,
  input  wire       link_speed_100,
  input  wire       link_activity,
  // captured strap images
  output reg        ctrl0_speed_select,
  output reg        an_adv_100_capable,
  output wire       strap_valid,
  // receive nibbles from the core
  input  wire [3:0] core_rx_nibble,
  input  wire       core_rx_valid,
  // receive nibbles to the mac
  output reg  [3:0] mii_rxd,
  output reg        mii_rx_dv,
  // transmit nibbles from the mac pins
  input  wire [3:0] mii_txd,
  input  wire       mii_tx_en,
  // transmit nibbles to the core
  output reg  [3:0] core_tx_nibble,
  output reg        core_tx_valid
);

  // strap sequence states
  localparam [2:0] ST_SETTLE = 3'h1;
  localparam [2:0] ST_SAMPLE = 3'h2;
  localparam [2:0] ST_RUN    = 3'h4;

  localparam CNT_W = 32;

  reg  [2:0]       state_reg;
  reg  [2:0]       state_next;
  reg  [1:0]       settle_reg;
  reg  [1:0]       settle_next;
  reg              pin_oe_reg;
  reg              lamp_reg;
  reg              lamp_next;
  reg              blink_reg;
  reg  [CNT_W-1:0] blink_cnt_reg;
  wire             pin_sync_level;
  wire [4:0]       tx_sync;
  wire             blink_wrap;

  // strap pin level into the clock domain
  pin_sync #(
    .WIDTH     (1),
    .RESET_VAL (`STRAP_PIN_DEFAULT)
  ) u_strap_sync (
    .clk      (clk),
    .arst_n   (arst_n),
    .async_in (speed_activity_indicator_pin_in),
    .sync_out (pin_sync_level)
  );

  // mac transmit pins into the clock domain
  pin_sync #(
    .WIDTH     (5),
    .RESET_VAL (5'h00)
  ) u_tx_sync (
    .clk      (clk),
    .arst_n   (arst_n),
    .async_in ({mii_tx_en, mii_txd}),
    .sync_out (tx_sync)
  );

  // strap sequence: settle the synchroniser, sample once, then run
  always @*
  begin
    state_next  = state_reg;
    settle_next = settle_reg;
    case (state_reg)
      ST_SETTLE:
      begin
        settle_next = settle_reg + 2'h1;
        if (settle_reg == `STRAP_SETTLE_CYC - 2'h1)
          state_next = ST_SAMPLE;
      end
      ST_SAMPLE:
      begin
        state_next = ST_RUN;
      end
      ST_RUN:
      begin
        state_next = ST_RUN;                        // never resamples
      end
      default:
      begin
        state_next  = ST_SETTLE;
        settle_next = 2'h0;
      end
    endcase
  end

  // state, strap capture and pin direction
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)                                    // all logic held in reset
    begin
      state_reg          <= ST_SETTLE;
      settle_reg         <= 2'h0;
      ctrl0_speed_select <= `STRAP_PIN_DEFAULT;
      an_adv_100_capable <= `STRAP_PIN_DEFAULT;
      pin_oe_reg         <= 1'b0;                   // input during reset
    end
    else
    begin
      state_reg  <= state_next;
      settle_reg <= settle_next;
      if (state_reg == ST_SAMPLE)
      begin
        ctrl0_speed_select <= pin_sync_level;       // high 100, low 10
        an_adv_100_capable <= pin_sync_level;       // advertised capability
        pin_oe_reg         <= 1'b1;                 // drive after capture
      end
    end
  end

  assign strap_valid = (state_reg == ST_RUN);

  // blink timer runs only while there is activity
  assign blink_wrap = (blink_cnt_reg == BLINK_HALF_CYC - 1);

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      blink_cnt_reg <= {CNT_W{1'b0}};
      blink_reg     <= `LAMP_OFF_LEVEL;
    end
    else if (!link_activity)
    begin
      blink_cnt_reg <= {CNT_W{1'b0}};
      blink_reg     <= `LAMP_OFF_LEVEL;             // high when idle
    end
    else if (blink_wrap)
    begin
      blink_cnt_reg <= {CNT_W{1'b0}};
      blink_reg     <= ~blink_reg;                  // toggle on activity
    end
    else
    begin
      blink_cnt_reg <= blink_cnt_reg + 1;
    end
  end

  // lamp function chosen by indicator mode
  always @*
  begin
    case (led_mode)                                 // mode field selects
      `LED_MODE_SPEED:
        lamp_next = link_speed_100 ? `LAMP_ON_LEVEL : `LAMP_OFF_LEVEL;
      `LED_MODE_ACT:
        lamp_next = link_activity ? blink_reg : `LAMP_OFF_LEVEL; // off when idle
      default:
        lamp_next = `LAMP_OFF_LEVEL;                // reserved modes dark
    endcase
  end

  // lamp level register, off until the strap is done
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      lamp_reg <= `LAMP_OFF_LEVEL;
    else if (strap_valid)
      lamp_reg <= lamp_next;
    else
      lamp_reg <= `LAMP_OFF_LEVEL;
  end

  assign speed_activity_indicator_pin_out = lamp_reg;
  assign speed_activity_indicator_pin_oe  = pin_oe_reg;

  // receive nibbles to the mac, data zeroed outside valid
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mii_rxd   <= 4'h0;
      mii_rx_dv <= 1'b0;
    end
    else
    begin
      mii_rx_dv <= core_rx_valid;                   // dv only with valid data
      mii_rxd   <= core_rx_valid ? core_rx_nibble : 4'h0;
    end
  end

  // transmit nibbles from the mac, taken only under tx enable
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      core_tx_nibble <= 4'h0;
      core_tx_valid  <= 1'b0;
    end
    else
    begin
      core_tx_valid  <= tx_sync[4];
      core_tx_nibble <= tx_sync[4] ? tx_sync[3:0] : 4'h0;
    end
  end

endmodule // led_strap_mii_pin_control

// ==== tb/led_strap_monitor.sv ====
// assertions on the lamp pin, strap capture and mii paths
module led_strap_monitor (
  // clock, reset and lamp control
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       link_speed_100,
  input wire logic       link_activity,
  input wire logic [1:0] led_mode,
  // lamp pin
  input wire logic       speed_activity_indicator_pin_out,
  input wire logic       speed_activity_indicator_pin_oe,
  // strap images
  input wire logic       ctrl0_speed_select,
  input wire logic       an_adv_100_capable,
  input wire logic       strap_valid,
  // mii receive path
  input wire logic       core_rx_valid,
  input wire logic [3:0] core_rx_nibble,
  input wire logic       mii_rx_dv,
  input wire logic [3:0] mii_rxd,
  // mii transmit path
  input wire logic       mii_tx_en,
  input wire logic [3:0] mii_txd,
  input wire logic       core_tx_valid,
  input wire logic [3:0] core_tx_nibble
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // mii paths, fixed latency and zeroed data
  AST_RX: assert property ($past(arst_n) |-> mii_rx_dv == $past(core_rx_valid) &&
    mii_rxd == ($past(core_rx_valid) ? $past(core_rx_nibble) : 4'h0)) else $error("rx path");
  AST_TX: assert property ($past(arst_n, 3) |-> core_tx_valid == $past(mii_tx_en, 3) &&
    core_tx_nibble == ($past(mii_tx_en, 3) ? $past(mii_txd, 3) : 4'h0)) else $error("tx path");
  // strap capture timing and hold
  AST_CAPTURE: assert property ($rose(strap_valid) |->
    $past(arst_n, 3) && !$past(arst_n, 4)) else $error("capture edge");
  AST_HOLD: assert property (strap_valid && $past(strap_valid) |->
    $stable(ctrl0_speed_select) && $stable(an_adv_100_capable)) else $error("strap moved");
  AST_ADV: assert property (strap_valid |-> an_adv_100_capable == ctrl0_speed_select)
    else $error("adv image");
  AST_OE: assert property (speed_activity_indicator_pin_oe == strap_valid)
    else $error("pin drive");
  // lamp function by mode
  AST_SPEED: assert property ($past(strap_valid) && $past(led_mode) == 2'h0 |->
    speed_activity_indicator_pin_out == !$past(link_speed_100)) else $error("speed lamp");
  AST_RSV: assert property ($past(strap_valid) && $past(led_mode[1]) |->
    speed_activity_indicator_pin_out) else $error("reserved lamp");
  AST_IDLE: assert property ($past(strap_valid) && $past(led_mode) == 2'h1 &&
    !$past(link_activity) |-> speed_activity_indicator_pin_out) else $error("idle lamp");
  C_RX: cover property (mii_rx_dv);
  C_TX: cover property (core_tx_valid);
  C_LOW: cover property ($rose(strap_valid) && !ctrl0_speed_select);
endmodule // led_strap_monitor

// ==== tb/board_model.sv ====
// board side of the lamp pin: strap drive and pull-up
module board_model (
  input  wire logic speed_activity_indicator_pin_out,
  input  wire logic speed_activity_indicator_pin_oe,
  input  wire logic strap_drv,
  input  wire logic strap_lvl,
  output wire logic speed_activity_indicator_pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // device drive once enabled, else strap resistor or pull-up
  assign speed_activity_indicator_pin_in = speed_activity_indicator_pin_oe ?
    speed_activity_indicator_pin_out : (strap_drv ? strap_lvl : 1'h1);
endmodule // board_model

// ==== tb/testbench.sv ====
// bench for the lamp pin, strap capture and mii paths
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, arst_n, link_speed_100, link_activity, strap_drv, strap_lvl, strap_valid;
  logic speed_activity_indicator_pin_in, speed_activity_indicator_pin_out;
  logic speed_activity_indicator_pin_oe, ctrl0_speed_select, an_adv_100_capable;
  logic core_rx_valid, mii_rx_dv, mii_tx_en, core_tx_valid;
  logic [1:0] led_mode;
  logic [3:0] core_rx_nibble, mii_rxd, mii_txd, core_tx_nibble;
  int n_fail, n_checks, rq[$], tq[$], lq[$];
  led_strap_mii_pin_control #(.BLINK_HALF_CYC(4)) u_led_strap_mii_pin_control (.*);
  board_model u_board_model (.*);
  initial
  begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  task chk(input logic [4:0] seen, exp, input string what);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wrap_up;
    if (n_fail == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // reset with a strap drive, then check the capture
  task do_reset(input logic d, l);
    int i;
    @(negedge clk);
    arst_n = 1'h0;
    strap_drv = d;
    strap_lvl = l;
    repeat (16) @(negedge clk);
    chk(speed_activity_indicator_pin_oe, 0, "oe");
    chk({speed_activity_indicator_pin_out, mii_rx_dv}, 2, "rst out");
    arst_n = 1'h1;
    for (i = 0; i < 8 && strap_valid !== 1'h1; i++)
      @(negedge clk);
    if (i == 8)
    begin
      n_fail++;
      wrap_up();
    end
    chk({ctrl0_speed_select, an_adv_100_capable}, d && !l ? 0 : 3, "strap");
    chk(speed_activity_indicator_pin_oe, 1, "oe");
  endtask
  // random traffic against queue models
  task run(input int n);
    rq.delete();
    tq.delete();
    lq.delete();
    repeat (n)
    begin
      @(negedge clk);
      if (rq.size() > 0) chk({mii_rx_dv, mii_rxd}, 5'(rq.pop_front()), "rx");
      if (tq.size() == 3)
        chk({core_tx_valid, core_tx_nibble}, 5'(tq.pop_front()), "tx");
      if (lq.size() > 0 && lq[0] < 0) lq.delete(0);
      if (lq.size() > 0)
        chk(speed_activity_indicator_pin_out, 5'(lq.pop_front()), "lamp");
      {core_rx_valid, core_rx_nibble, mii_tx_en, mii_txd, led_mode, link_speed_100,
        link_activity} = 14'($urandom);
      rq.push_back(core_rx_valid ? {1'h1, core_rx_nibble} : 0);
      tq.push_back(mii_tx_en ? {1'h1, mii_txd} : 0);
      lq.push_back(led_mode == 2'h0 ? !link_speed_100 :
        led_mode == 2'h1 && link_activity ? -1 : 1);
    end
  endtask
  // activity blink count, then idle lamp off
  task blink;
    int t;
    logic p;
    @(negedge clk);
    led_mode = 2'h1;
    link_activity = 1'h1;
    t = 0;
    repeat (40)
    begin
      p = speed_activity_indicator_pin_out;
      @(negedge clk);
      t += int'(p !== speed_activity_indicator_pin_out);
    end
    chk(t >= 7 && t <= 11, 1, "blink");
    link_activity = 1'h0;
    repeat (2) @(negedge clk);
    chk(speed_activity_indicator_pin_out, 1, "idle");
  endtask
  initial
  begin
    {arst_n, strap_drv, strap_lvl, led_mode, link_speed_100, link_activity} = 7'h00;
    {core_rx_valid, core_rx_nibble, mii_tx_en, mii_txd} = 10'h000;
    n_fail = 0;
    n_checks = 0;
    void'($urandom(32'hCE5EC2B5));
    do_reset(1'h1, 1'h0);
    run(300);
    chk(ctrl0_speed_select, 0, "held");
    blink();
    do_reset(1'h1, 1'h1);
    run(300);
    do_reset(1'h0, 1'h0);
    run(300);
    wrap_up();
  end
endmodule // testbench
bind led_strap_mii_pin_control led_strap_monitor u_led_strap_monitor (.*);
